/* File: logic/stc_defs.svh */
// Register offsets, field positions, reset values and oscillator timing
// for the sample and timing clock configuration block.
// Assumes inclusion by bare name from design and bench files.
`ifndef STC_DEFS_SVH
`define STC_DEFS_SVH

`define STC_ADDR_SLOT_CTRL 8'h11
`define STC_ADDR_EXT_START 8'h38
`define STC_ADDR_SLOW_CTRL 8'h4b
`define STC_ADDR_FAST_TRIM 8'h4d
`define STC_ADDR_PIN_CFG 8'h4f

`define STC_RST_SLOT_CTRL 16'h0000
`define STC_RST_EXT_START 16'h0000
`define STC_RST_SLOW_CTRL 16'h2612
`define STC_RST_FAST_TRIM 16'h0098
`define STC_RST_PIN_CFG 16'h2090

`define STC_EXT_START_PIN 16'h4000

`define STC_BIT_SLOT_EN 0
`define STC_BIT_BYPASS 8
`define STC_BIT_CLK_EN 7
`define STC_SLOW_TRIM_MSB 5
`define STC_FAST_TRIM_MSB 7
`define STC_BIT_AUX0_IE 1
`define STC_BIT_AUX1_IE 5
`define STC_BIT_AUX1_OE 6
`define STC_SRC_LSB 2

`define STC_SLOW_TRIM_RST 6'h12
`define STC_FAST_TRIM_RST 8'h98

// Internal sample oscillator model: period in sys_clk cycles is base + trim
`define STC_OSC_BASE 7'h10

`endif

/* File: logic/stc_pkg.sv */
// Types shared by the sample and timing clock configuration block.
// Assumes stc_defs.svh carries all numeric constants.
package stc_pkg;

  typedef enum logic [1:0] {
    STC_SRC_INTERNAL,
    STC_SRC_FIRST_PIN,
    STC_SRC_SECOND_PIN,
    STC_SRC_RESERVED
  } stc_src_t;

endpackage : stc_pkg

/* File: logic/stc_slow_osc.sv */
// Digital stand-in for the slow sample oscillator: one tick per period.
// Assumes a single sys_clk domain and a trim that may change at any time.
`timescale 1ns/1ps
`include "stc_defs.svh"

module stc_slow_osc (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic [5:0] trim,
  // Output
  output logic tick
);

  logic [6:0] cnt;
  logic [6:0] period;
  logic [6:0] next_cnt;
  logic next_tick;

  assign period = `STC_OSC_BASE + {1'b0, trim};
  assign next_tick = run && (cnt >= period - 7'h01);
  assign next_cnt = (!run || next_tick) ? 7'h00 : cnt + 7'h01;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt <= 7'h00;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

  // Helper: cycles since last tick, and whether trim stayed put
  logic [6:0] gap;
  logic steady;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gap <= 7'h00;
      steady <= 1'b0;
    end else begin
      gap <= tick ? 7'h01 : gap + 7'h01;
      steady <= tick ? run : (steady && run && trim == $past(trim));
    end
  end

  osc_period_a: assert property (@(posedge sys_clk) disable iff (rst)
    (tick && steady && run && trim == $past(trim)) |-> (gap == period))
    else $error("slow oscillator tick spacing differs from base plus trim");

  osc_stop_a: assert property (@(posedge sys_clk) disable iff (rst)
    !run |=> !tick)
    else $error("slow oscillator ticked while stopped");

endmodule : stc_slow_osc

/* File: logic/stc_clock_config.sv */
// Sample and timing clock configuration registers and sample clock gating.
// Assumes a register port fed by the serial host decoder on sys_clk;
// aux pins arrive asynchronously and are synchronised here.
//
// Behaviour
// - Bit 0 of the slot control register turns the first time slot on when 1.
// - Bypass bit 8 clear runs the internal oscillator; set takes the clock from the second pin.
// - Enable bit 7 gates the sample clock; 0 stops it, 1 runs it.
// - Bits 5..0 trim the slow oscillator, reset 0x12, about 0.6 kHz per step.
// - The slow trim is inverse: larger codes give a lower frequency.
// - An 8-bit field trims the fast timing oscillator, reset 0x98, about 109 kHz per step.
// - The fast trim is direct: larger codes give a higher frequency.
// - The second pin has input enable at bit 5 and output enable at bit 6 of pin config.
// - A 2-bit code picks the trigger: 00 internal, 01 first pin, 10 second pin, 11 none.
`timescale 1ns/1ps
`include "stc_defs.svh"

module stc_clock_config (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Aux pins
  input wire logic first_aux_pin_in,
  input wire logic second_aux_pin_in,
  output logic second_aux_pin_out,
  output logic second_pin_oe_n,
  // Clock and timing controls
  output logic first_slot_enable,
  output logic [5:0] slow_osc_trim,
  output logic [7:0] fast_osc_trim,
  output logic sample_clk_tick,
  output logic sample_trigger
);

  logic [15:0] slot_ctrl;
  logic [15:0] external_trigger_startup;
  logic [15:0] slow_oscillator_control;
  logic [15:0] fast_oscillator_trim;
  logic [15:0] pin_cfg;

  // Address decode
  wire hit_slot = (reg_addr == `STC_ADDR_SLOT_CTRL);
  wire hit_ext = (reg_addr == `STC_ADDR_EXT_START);
  wire hit_slow = (reg_addr == `STC_ADDR_SLOW_CTRL);
  wire hit_fast = (reg_addr == `STC_ADDR_FAST_TRIM);
  wire hit_pin = (reg_addr == `STC_ADDR_PIN_CFG);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      slot_ctrl <= `STC_RST_SLOT_CTRL;
      external_trigger_startup <= `STC_RST_EXT_START;
      slow_oscillator_control <= `STC_RST_SLOW_CTRL;
      fast_oscillator_trim <= `STC_RST_FAST_TRIM;
      pin_cfg <= `STC_RST_PIN_CFG;
    end else if (reg_wr) begin
      if (hit_slot) slot_ctrl <= reg_wdata;
      if (hit_ext) external_trigger_startup <= reg_wdata;
      if (hit_slow) slow_oscillator_control <= reg_wdata;
      if (hit_fast) fast_oscillator_trim <= reg_wdata;
      if (hit_pin) pin_cfg <= reg_wdata;
    end
  end

  // Unmapped addresses read as zero
  wire [15:0] next_rdata = hit_slot ? slot_ctrl :
                           hit_ext ? external_trigger_startup :
                           hit_slow ? slow_oscillator_control :
                           hit_fast ? fast_oscillator_trim :
                           hit_pin ? pin_cfg : 16'h0000;

  // Field views
  wire slow_osc_bypass = slow_oscillator_control[`STC_BIT_BYPASS];
  wire sample_clock_enable = slow_oscillator_control[`STC_BIT_CLK_EN];
  wire second_pin_input_enable = pin_cfg[`STC_BIT_AUX1_IE];
  wire second_pin_output_enable = pin_cfg[`STC_BIT_AUX1_OE];
  wire first_pin_input_enable = pin_cfg[`STC_BIT_AUX0_IE];
  wire [1:0] src_bits = pin_cfg[`STC_SRC_LSB+1:`STC_SRC_LSB];
  stc_pkg::stc_src_t sample_trigger_source;
  assign sample_trigger_source = stc_pkg::stc_src_t'(src_bits);

  // Two-flop synchronisers, then edge history
  logic aux0_s1, aux0_s2, aux0_q;
  logic aux1_s1, aux1_s2, aux1_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aux0_s1 <= 1'b0;
      aux0_s2 <= 1'b0;
      aux0_q <= 1'b0;
      aux1_s1 <= 1'b0;
      aux1_s2 <= 1'b0;
      aux1_q <= 1'b0;
    end else begin
      aux0_s1 <= first_aux_pin_in;
      aux0_s2 <= aux0_s1;
      aux0_q <= aux0_s2;
      aux1_s1 <= second_aux_pin_in;
      aux1_s2 <= aux1_s1;
      aux1_q <= aux1_s2;
    end
  end

  wire aux0_rise = first_pin_input_enable && aux0_s2 && !aux0_q;
  wire aux1_rise = second_pin_input_enable && aux1_s2 && !aux1_q;

  // bypass selection; oscillator idles while bypassed or gated off
  logic osc_tick;
  wire osc_run = sample_clock_enable && !slow_osc_bypass;
  stc_slow_osc u_slow_osc (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(osc_run),
    .trim(slow_osc_trim),
    .tick(osc_tick)
  );
  wire raw_tick = slow_osc_bypass ? aux1_rise : osc_tick;

  wire next_sample_tick = sample_clock_enable && raw_tick;

  logic next_trigger;
  always_comb begin
    case (sample_trigger_source)
      stc_pkg::STC_SRC_INTERNAL: next_trigger = next_sample_tick;
      stc_pkg::STC_SRC_FIRST_PIN: next_trigger = aux0_rise;
      stc_pkg::STC_SRC_SECOND_PIN: next_trigger = aux1_rise;
      default: next_trigger = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
      first_slot_enable <= 1'b0;
      slow_osc_trim <= `STC_SLOW_TRIM_RST;
      fast_osc_trim <= `STC_FAST_TRIM_RST;
      sample_clk_tick <= 1'b0;
      sample_trigger <= 1'b0;
      second_aux_pin_out <= 1'b0;
      second_pin_oe_n <= 1'b1;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 16'h0000;
      reg_rvalid <= reg_rd;
      first_slot_enable <= slot_ctrl[`STC_BIT_SLOT_EN];
      slow_osc_trim <= slow_oscillator_control[`STC_SLOW_TRIM_MSB:0];
      fast_osc_trim <= fast_oscillator_trim[`STC_FAST_TRIM_MSB:0];
      sample_clk_tick <= next_sample_tick;
      sample_trigger <= next_trigger;
      // Pin drives low when output enabled; drive source select is outside
      second_aux_pin_out <= 1'b0;
      second_pin_oe_n <= !second_pin_output_enable;
    end
  end

  slot_enable_a: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_wr && hit_slot) |=> ##1 (first_slot_enable == $past(reg_wdata[0], 2)))
    else $error("slot enable does not follow written bit");

  bypass_ext_a: assert property (@(posedge sys_clk) disable iff (rst)
    (slow_osc_bypass && sample_clock_enable && aux1_rise) |=> sample_clk_tick)
    else $error("bypassed sample clock missed external edge");

  bypass_int_a: assert property (@(posedge sys_clk) disable iff (rst)
    (slow_osc_bypass && !aux1_rise) |=> !sample_clk_tick)
    else $error("bypassed sample clock ticked without external edge");

  clk_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    !sample_clock_enable |=> !sample_clk_tick)
    else $error("sample clock ticked while disabled");

  slow_reset_a: assert property (@(posedge sys_clk)
    rst |=> (slow_osc_trim == `STC_SLOW_TRIM_RST && fast_osc_trim == `STC_FAST_TRIM_RST))
    else $error("trim outputs not at reset values");

  fast_trim_a: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_wr && hit_fast) |=> ##1 (fast_osc_trim == $past(reg_wdata[7:0], 2)))
    else $error("fast trim does not follow written code");

  pin_oe_a: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_wr && hit_pin) |=> ##1 (second_pin_oe_n == !$past(reg_wdata[6], 2)))
    else $error("second pin output enable does not follow bit 6");

  trig_pin_a: assert property (@(posedge sys_clk) disable iff (rst)
    (src_bits == 2'h2 && aux1_rise) |=> sample_trigger)
    else $error("second pin edge did not trigger a sample");

  trig_none_a: assert property (@(posedge sys_clk) disable iff (rst)
    (src_bits == 2'h3) |=> !sample_trigger)
    else $error("reserved trigger source produced a trigger");

  readback_a: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_wr && hit_ext && !reg_rd) ##1 !reg_wr ##1 (reg_rd && hit_ext && !reg_wr)
      |=> (reg_rvalid && reg_rdata == $past(reg_wdata, 3)))
    else $error("register did not read back last written value");

endmodule : stc_clock_config

/* File: bench/stc_host_model.sv */
// Host model: drives the register port of the clock configuration block.
// Assumes the bench calls its tasks and everything runs on sys_clk.
`timescale 1ns/1ps
`include "stc_defs.svh"

module stc_host_model (
  // Clock
  input wire logic sys_clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Idle lines flip so a stale address or word never looks valid
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [15:0] d, output logic ok);
    ok = 1'b0;
    d = 16'h0000;
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    // Answer is taken at the edge that samples it, before it drops again
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge sys_clk);
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d = reg_rdata;
      end
    end
  endtask : read_reg

  task automatic set_source(input logic [1:0] src);
    write_reg(`STC_ADDR_PIN_CFG, 16'h20b2 | {12'h000, src, 2'b00});
    write_reg(`STC_ADDR_EXT_START, (src == 2'b01 || src == 2'b10) ? `STC_EXT_START_PIN : 16'h0000);
  endtask : set_source
endmodule : stc_host_model

/* File: bench/stc_clock_config_tb_top.sv */
// Self-checking bench for the sample and timing clock configuration block.
// Assumes the host model owns the register port; the bench drives the pins.
`timescale 1ns/1ps
`include "stc_defs.svh"

module stc_clock_config_tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic first_aux_pin_in = 1'b0;
  logic second_aux_pin_in = 1'b0;
  logic [7:0] reg_addr, fast_osc_trim;
  logic [15:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, reg_rvalid, second_aux_pin_out, second_pin_oe_n;
  logic first_slot_enable, sample_clk_tick, sample_trigger;
  logic [5:0] slow_osc_trim;
  logic [31:0] seed = 32'h0000002b;
  int failures = 0;
  int samples_checked = 0;
  int ticks = 0;
  int trigs = 0;

  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    ticks <= ticks + (sample_clk_tick === 1'b1);
    trigs <= trigs + (sample_trigger === 1'b1);
  end

  stc_host_model stc_host_model_i (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .reg_rvalid);
  stc_clock_config stc_clock_config_i (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .reg_rvalid, .first_aux_pin_in, .second_aux_pin_in,
    .second_aux_pin_out, .second_pin_oe_n, .first_slot_enable, .slow_osc_trim,
    .fast_osc_trim, .sample_clk_tick, .sample_trigger);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic results();
    $display("Checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    stc_host_model_i.read_reg(a, d, ok);
    if (!ok) begin
      failures++;
      $display("ERROR %0t read answer missing", $time);
      results();
    end
    check(d, exp);
  endtask : rd_chk

  task automatic wait_tick(output int n);
    for (n = 1; n <= 200; n++) begin
      @(posedge sys_clk);
      #1;
      if (sample_clk_tick === 1'b1) return;
    end
    failures++;
    $display("ERROR %0t sample tick missing", $time);
    results();
  endtask : wait_tick

  task automatic pulse_pins(input int hi);
    @(posedge sys_clk);
    first_aux_pin_in <= 1'b1;
    second_aux_pin_in <= 1'b1;
    repeat (hi) @(posedge sys_clk);
    first_aux_pin_in <= 1'b0;
    second_aux_pin_in <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : pulse_pins

  initial begin
    logic [15:0] d;
    logic [5:0] t;
    int n, t0, g0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(`STC_ADDR_SLOT_CTRL, `STC_RST_SLOT_CTRL);
    rd_chk(`STC_ADDR_EXT_START, `STC_RST_EXT_START);
    rd_chk(`STC_ADDR_SLOW_CTRL, `STC_RST_SLOW_CTRL);
    rd_chk(`STC_ADDR_FAST_TRIM, `STC_RST_FAST_TRIM);
    rd_chk(`STC_ADDR_PIN_CFG, `STC_RST_PIN_CFG);
    rd_chk(8'h20, 16'h0000);
    check({8'h00, fast_osc_trim}, 16'h0098);
    check({10'h000, slow_osc_trim}, 16'h0012);
    check({15'h0000, second_pin_oe_n}, 16'h0001);
    check({15'h0000, second_aux_pin_out}, 16'h0000);
    $display("Test reset values done");
    // Extremes first, then random words
    for (int i = 0; i < 14; i++) begin
      seed = xs(seed);
      d = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : seed[15:0];
      stc_host_model_i.write_reg(`STC_ADDR_FAST_TRIM, d);
      stc_host_model_i.write_reg(`STC_ADDR_SLOT_CTRL, ~d);
      rd_chk(`STC_ADDR_FAST_TRIM, d);
      rd_chk(`STC_ADDR_SLOT_CTRL, ~d);
      check({8'h00, fast_osc_trim}, {8'h00, d[7:0]});
      check({15'h0000, first_slot_enable}, {15'h0000, ~d[0]});
    end
    $display("Test register traffic done");
    // period grows with the trim code
    for (int i = 0; i < 5; i++) begin
      seed = xs(seed);
      t = (i == 0) ? 6'h00 : (i == 1) ? 6'h22 : (i == 2) ? 6'h3f : seed[5:0];
      stc_host_model_i.write_reg(`STC_ADDR_SLOW_CTRL, 16'h2680 | {10'h000, t});
      wait_tick(n);
      wait_tick(n);
      wait_tick(n);
      check(n[15:0], 16'h0010 + {10'h000, t});
      check({10'h000, slow_osc_trim}, {10'h000, t});
    end
    stc_host_model_i.write_reg(`STC_ADDR_SLOW_CTRL, 16'h2612);
    repeat (4) @(posedge sys_clk);
    t0 = ticks;
    repeat (120) @(posedge sys_clk);
    check(16'(ticks - t0), 16'h0000);
    $display("Test internal sample clock done");
    stc_host_model_i.set_source(2'b00);
    stc_host_model_i.write_reg(`STC_ADDR_SLOW_CTRL, 16'h2780);
    repeat (4) @(posedge sys_clk);
    t0 = ticks;
    repeat (5) pulse_pins(4);
    repeat (8) @(posedge sys_clk);
    check(16'(ticks - t0), 16'h0005);
    stc_host_model_i.write_reg(`STC_ADDR_PIN_CFG, 16'h20d0);
    repeat (2) @(posedge sys_clk);
    #1;
    check({15'h0000, second_pin_oe_n}, 16'h0000);
    check({15'h0000, second_aux_pin_out}, 16'h0000);
    $display("Test bypass and pin enables done");
    for (int s = 0; s < 4; s++) begin
      stc_host_model_i.write_reg(`STC_ADDR_SLOW_CTRL, (s == 0) ? 16'h2680 : 16'h2600);
      stc_host_model_i.set_source(s[1:0]);
      rd_chk(`STC_ADDR_EXT_START, (s == 1 || s == 2) ? `STC_EXT_START_PIN : 16'h0000);
      repeat (4) @(posedge sys_clk);
      t0 = ticks;
      g0 = trigs;
      pulse_pins(4);
      repeat (40) @(posedge sys_clk);
      n = (s == 0) ? ticks - t0 : (s == 3) ? 0 : 1;
      check(16'(trigs - g0), n[15:0]);
    end
    $display("Test trigger sources done");
    results();
  end
endmodule : stc_clock_config_tb_top
